/* File: hw/sso_ctrl.sv */
`timescale 1ns/10ps
`include "sso_map.svh"
module sso_ctrl
   import sso_pkg::*;
#(
   parameter int DATA_W = `SSO_DATA_W,
   parameter int ADDR_W = `SSO_ADDR_W
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic sleep_request_i,
   input wire logic chip_select_a_n_i,
   input wire logic chip_select_b_i,
   input wire logic address_advance_n_i,
   input wire logic write_enable_n_i,
   input wire logic output_enable_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   output logic sleep_active_o
);
   localparam logic [1:0] WAKE_LAST = `SSO_WAKE_CYC - 2'h1;

   logic sleep_sync;
   sso_state_t state;
   sso_state_t next_state;
   logic [1:0] wake_cnt;
   logic [1:0] next_wake_cnt;
   logic s1_valid;
   logic s1_write;
   logic [ADDR_W-1:0] s1_addr;
   logic s2_valid;
   logic s2_write;
   logic [ADDR_W-1:0] s2_addr;
   logic next_s1_valid;
   logic next_s1_write;
   logic [ADDR_W-1:0] next_s1_addr;
   logic next_s2_valid;
   logic next_s2_write;
   logic [ADDR_W-1:0] next_s2_addr;
   logic [DATA_W-1:0] next_dq;
   logic next_dq_oe;
   logic next_sleep_active;
   logic cmd_sel;
   logic cmd_accept;
   logic read_issue;
   logic write_issue;
   logic mem_we;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // The sleep pin is asynchronous, so it is brought in through two flops.
   sso_sync #(
      .WIDTH(1)
   ) u_sleep_sync (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .async_i(sleep_request_i),
      .sync_o(sleep_sync)
   );

   // A command needs every chip select active on an advance-low edge.
   assign cmd_sel = !chip_select_a_n_i && chip_select_b_i && !address_advance_n_i;
   // Writes are refused during wake-up so a misbehaving controller cannot corrupt data.
   assign cmd_accept = cmd_sel && ((state == SSO_AWAKE) ||
                       (state == SSO_WAKE && write_enable_n_i));
   assign read_issue = cmd_accept && write_enable_n_i;
   assign write_issue = cmd_accept && !write_enable_n_i;
   assign mem_we = s2_valid && s2_write;

   always_comb begin
      next_state = state;
      next_wake_cnt = wake_cnt;
      unique case (state)
         SSO_AWAKE: begin
            if (sleep_sync) begin
               next_state = SSO_SLEEP;
            end
         end
         SSO_SLEEP: begin
            if (!sleep_sync) begin
               next_state = SSO_WAKE;
               next_wake_cnt = 2'h0;
            end
         end
         SSO_WAKE: begin
            if (sleep_sync) begin
               next_state = SSO_SLEEP;
            end else if (wake_cnt == WAKE_LAST) begin
               next_state = SSO_AWAKE;
            end else begin
               next_wake_cnt = wake_cnt + 2'h1;
            end
         end
      endcase
      next_sleep_active = (next_state == SSO_SLEEP);
   end

   // Operations still in stage 1 at sleep entry are dropped; a write already in stage 2 still lands in the first sleep cycle.
   always_comb begin
      next_s1_valid = read_issue || write_issue;
      next_s1_write = write_issue;
      next_s1_addr = cmd_accept ? addr_i : s1_addr;
      next_s2_valid = s1_valid && (state != SSO_SLEEP);
      next_s2_write = s1_write;
      next_s2_addr = s1_addr;
   end

   always_comb begin
      next_dq_oe = s2_valid && !s2_write && !output_enable_n_i &&
                   !sleep_sync && (state != SSO_SLEEP);
      next_dq = (s2_valid && !s2_write) ? mem[s2_addr] : dq_o;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state <= SSO_AWAKE;
         wake_cnt <= 2'h0;
         s1_valid <= 1'h0;
         s1_write <= 1'h0;
         s1_addr <= '0;
         s2_valid <= 1'h0;
         s2_write <= 1'h0;
         s2_addr <= '0;
         dq_o <= '0;
         dq_oe_o <= `SSO_RST_DQ_OE;
         sleep_active_o <= `SSO_RST_SLEEP;
      end else begin
         state <= next_state;
         wake_cnt <= next_wake_cnt;
         s1_valid <= next_s1_valid;
         s1_write <= next_s1_write;
         s1_addr <= next_s1_addr;
         s2_valid <= next_s2_valid;
         s2_write <= next_s2_write;
         s2_addr <= next_s2_addr;
         dq_o <= next_dq;
         dq_oe_o <= next_dq_oe;
         sleep_active_o <= next_sleep_active;
      end
   end

   // The array has no reset, so its contents outlive both sleep and reset.
   always_ff @(posedge mclk_i) begin
      if (mem_we) begin
         mem[s2_addr] <= dq_i;
      end
   end

   property p_sleep_ignore;
      @(posedge mclk_i) disable iff (reset_i)
      (state == SSO_SLEEP) |=> !s1_valid;
   endproperty
   a_sleep_ignore: assert property (p_sleep_ignore) else $error("command taken in sleep");

   property p_sleep_hiz;
      @(posedge mclk_i) disable iff (reset_i)
      sleep_sync |=> !dq_oe_o;
   endproperty
   a_sleep_hiz: assert property (p_sleep_hiz) else $error("pins driven in sleep");

   property p_oe_release;
      @(posedge mclk_i) disable iff (reset_i)
      output_enable_n_i |=> !dq_oe_o;
   endproperty
   a_oe_release: assert property (p_oe_release) else $error("pins driven with oe high");

   property p_read_timing;
      @(posedge mclk_i) disable iff (reset_i)
      read_issue ##1 (state != SSO_SLEEP) ##1
         (!output_enable_n_i && !sleep_sync && state != SSO_SLEEP)
         |=> dq_oe_o && (dq_o == $past(mem[s2_addr]));
   endproperty
   a_read_timing: assert property (p_read_timing) else $error("read data late or wrong");

   property p_write_store;
      @(posedge mclk_i) disable iff (reset_i)
      (s2_valid && s2_write) |=> mem[$past(s2_addr)] == $past(dq_i);
   endproperty
   a_write_store: assert property (p_write_store) else $error("write data not stored");

   property p_drive_only_read;
      @(posedge mclk_i) disable iff (reset_i)
      dq_oe_o |-> $past(s2_valid) && !$past(s2_write);
   endproperty
   a_drive_only_read: assert property (p_drive_only_read) else $error("pins driven off read");

   property p_sleep_enter;
      @(posedge mclk_i) disable iff (reset_i)
      sleep_sync |=> (state == SSO_SLEEP) && sleep_active_o;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

   property p_sleep_exit;
      @(posedge mclk_i) disable iff (reset_i)
      (state == SSO_SLEEP && !sleep_sync) |=> (state == SSO_WAKE) ##2 (state == SSO_AWAKE);
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit wrong");

   property p_entry_min;
      @(posedge mclk_i) disable iff (reset_i)
      ($rose(sleep_request_i) && state != SSO_SLEEP && !sleep_sync)
         |=> (state != SSO_SLEEP)[*2];
   endproperty
   a_entry_min: assert property (p_entry_min) else $error("sleep entered too early");

   property p_retain;
      @(posedge mclk_i) disable iff (reset_i)
      (state == SSO_SLEEP && $past(state) == SSO_SLEEP) |-> !mem_we;
   endproperty
   a_retain: assert property (p_retain) else $error("array written in sleep");

   c_read_out: cover property (@(posedge mclk_i) disable iff (reset_i) read_issue ##3 dq_oe_o);
   c_write: cover property (@(posedge mclk_i) disable iff (reset_i) write_issue ##2 mem_we);
   c_sleep: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(sleep_active_o));
   c_wake: cover property (@(posedge mclk_i) disable iff (reset_i)
      state == SSO_WAKE ##1 state == SSO_WAKE ##1 state == SSO_AWAKE);

endmodule : sso_ctrl

/* File: common/sso_map.svh */
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH

// Array geometry: 512K words of 36 bits.
`define SSO_DATA_W 36
`define SSO_ADDR_W 19

// Clock edges from a command edge to its data edge (read out or write in).
`define SSO_PIPE_CYC 2

// Least clock cycles from sleep request high to inputs ignored.
`define SSO_SLEEP_ENTRY_CYC 2

// Least clock cycles of wake-up after sleep request low.
`define SSO_WAKE_CYC 2'h2

// Reset values of the registered dq_oe_o and sleep_active_o outputs.
`define SSO_RST_DQ_OE 1'h0
`define SSO_RST_SLEEP 1'h0

`endif

/* File: common/sso_pkg.sv */
package sso_pkg;

   typedef enum logic [1:0] {
      SSO_AWAKE,
      SSO_SLEEP,
      SSO_WAKE
   } sso_state_t;

endpackage : sso_pkg

/* File: hw/sso_sync.sv */
`timescale 1ns/10ps
module sso_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync;

   // The first stage feeds only the second stage.
   always_comb begin
      next_meta = async_i;
      next_sync = meta;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= next_meta;
         sync_o <= next_sync;
      end
   end

endmodule : sso_sync

/* File: tb/sso_ctl_model.sv */
`timescale 1ns/10ps
module sso_ctl_model #(
   parameter int DATA_W = 36,
   parameter int ADDR_W = 19
) (
   input wire logic mclk_i,
   output logic chip_select_a_n_o,
   output logic chip_select_b_o,
   output logic address_advance_n_o,
   output logic write_enable_n_o,
   output logic output_enable_n_o,
   output logic sleep_request_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] dq_o
);
   initial begin
      chip_select_a_n_o = 1'h1;
      chip_select_b_o = 1'h0;
      address_advance_n_o = 1'h1;
      write_enable_n_o = 1'h1;
      output_enable_n_o = 1'h1;
      sleep_request_o = 1'h0;
      addr_o = '0;
      dq_o = 36'h5A5A5A5A5;
   end
   // Released data lines take the inverse of their last value on each idle, so a second idle brings the last word back.
   task automatic idle();
      @(negedge mclk_i);
      address_advance_n_o = 1'h1;
      chip_select_a_n_o = 1'h1;
      chip_select_b_o = 1'h0;
      output_enable_n_o = 1'h1;
      addr_o = ~addr_o;
      dq_o = ~dq_o;
   endtask : idle
   task automatic op(input logic sel, input logic we_n, input logic oe_n,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge mclk_i);
      chip_select_a_n_o = ~sel;
      chip_select_b_o = sel;
      address_advance_n_o = 1'h0;
      write_enable_n_o = we_n;
      addr_o = a;
      idle();
      @(negedge mclk_i);
      output_enable_n_o = oe_n;
      dq_o = d;
   endtask : op
   // The request only rises from an idle bus, and only idles follow its fall.
   task automatic nap(input logic v);
      idle();
      sleep_request_o = v;
      if (!v) begin
         repeat (6) idle();
      end
   endtask : nap
endmodule : sso_ctl_model

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`include "sso_map.svh"
module tb_top;
   typedef struct packed {
      logic sel;
      logic we_n;
      logic oe_n;
      logic [`SSO_ADDR_W-1:0] a;
      logic [`SSO_DATA_W-1:0] d;
      logic oe;
   } sso_row_t;
   logic mclk_i = 1'h0;
   logic reset_i = 1'h1;
   logic cs_a_n, cs_b, adv_n, we_n, oe_n, zz_req, dq_oe_o, sleep_active_o;
   logic [`SSO_ADDR_W-1:0] addr;
   logic [`SSO_DATA_W-1:0] dq_in, dq_o;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   sso_row_t rows [5] = '{
      '{1'h1, 1'h0, 1'h0, 19'h00001, 36'h123456789, 1'h0},
      '{1'h1, 1'h0, 1'h0, 19'h7FFFF, 36'hFEDCBA987, 1'h0},
      '{1'h1, 1'h1, 1'h0, 19'h00001, 36'h123456789, 1'h1},
      '{1'h1, 1'h1, 1'h0, 19'h7FFFF, 36'hFEDCBA987, 1'h1},
      '{1'h1, 1'h1, 1'h1, 19'h00001, 36'h123456789, 1'h0}};
   always #5 mclk_i = ~mclk_i;
   sso_ctl_model u_ctl (.mclk_i(mclk_i), .chip_select_a_n_o(cs_a_n), .chip_select_b_o(cs_b),
      .address_advance_n_o(adv_n), .write_enable_n_o(we_n), .output_enable_n_o(oe_n),
      .sleep_request_o(zz_req), .addr_o(addr), .dq_o(dq_in));
   sso_ctrl u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .sleep_request_i(zz_req),
      .chip_select_a_n_i(cs_a_n), .chip_select_b_i(cs_b), .address_advance_n_i(adv_n),
      .write_enable_n_i(we_n), .output_enable_n_i(oe_n), .addr_i(addr), .dq_i(dq_in),
      .dq_o(dq_o), .dq_oe_o(dq_oe_o), .sleep_active_o(sleep_active_o));
   task automatic wrap_up();
      if (fails == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [`SSO_DATA_W-1:0] got, input logic [`SSO_DATA_W-1:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_word
   // Issues one command and looks at the pins in the cycle the read word stands.
   task automatic run(input sso_row_t r);
      u_ctl.op(r.sel, r.we_n, r.oe_n, r.a, r.d);
      @(negedge mclk_i);
      chk_bit(dq_oe_o, r.oe);
      if (r.oe) begin
         chk_word(dq_o, r.d);
      end
      u_ctl.idle();
   endtask : run
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(negedge mclk_i);
      reset_i = 1'h0;
      chk_bit(dq_oe_o, 1'h0);
      chk_bit(sleep_active_o, 1'h0);
      foreach (rows[i]) begin
         run(rows[i]);
      end
      run('{1'h0, 1'h1, 1'h0, 19'h00001, 36'h0, 1'h0});
      u_ctl.nap(1'h1);
      repeat (2) begin
         @(negedge mclk_i);
         chk_bit(sleep_active_o, 1'h0);
      end
      @(negedge mclk_i);
      chk_bit(sleep_active_o, 1'h1);
      run('{1'h1, 1'h0, 1'h0, 19'h00001, 36'h0AAAAAAAA, 1'h0});
      run('{1'h1, 1'h1, 1'h0, 19'h00001, 36'h0, 1'h0});
      chk_bit(sleep_active_o, 1'h1);
      u_ctl.nap(1'h0);
      chk_bit(sleep_active_o, 1'h0);
      run('{1'h1, 1'h1, 1'h0, 19'h00001, 36'h123456789, 1'h1});
      run(rows[3]);
      wrap_up();
   end
endmodule : tb_top
